// ==== rtl/uart_consts.vh ====
`ifndef UART_CONSTS_VH
`define UART_CONSTS_VH

// Register offsets on the three address pins
`define OFS_DATA        3'h0
`define OFS_IER_DIVHI   3'h1
`define OFS_IIR         3'h2
`define OFS_LCR         3'h3
`define OFS_MCR         3'h4
`define OFS_LSR         3'h5
`define OFS_MSR         3'h6
`define OFS_SCR         3'h7

// Line control fields
`define LCR_DIVSEL      7
`define LCR_BREAK       6
`define LCR_STICK       5
`define LCR_EPS         4
`define LCR_PEN         3
`define LCR_STB         2

// Interrupt enable and modem control fields and writable masks
`define IER_RXD         0
`define IER_HOLDING_EMPTY_FLAG        1
`define IER_LINE        2
`define IER_MODEM       3
`define IER_MASK        8'h0f
`define MCR_MASK        8'h1f
`define MCR_LOOP        4

// Identification codes, bit 0 low means pending
`define IIR_NONE        3'h1
`define IIR_LINE        3'h6
`define IIR_RXD         3'h4
`define IIR_HOLDING_EMPTY_FLAG        3'h2
`define IIR_MODEM       3'h0

// Reset values
`define IER_RESET       8'h00
`define LCR_RESET       8'h03
`define MCR_RESET       8'h00
`define DIV_RESET       16'h0001
`define PIN_IDLE        18'h0007f

// Oversampling: ticks per bit, or per whole two or one-and-a-half bit stop, minus one
`define TICKS_BIT       5'h0f
`define TICKS_STOP2     5'h1f
`define TICKS_STOP15    5'h17

`endif

// ==== rtl/tx_buffer.v ====
module tx_buffer #(
    parameter WIDTH = 8,
    parameter DEPTH = 2
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg  [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg              wr_ptr_r;
    reg              rd_ptr_r;
    reg  [1:0]       count_r;
    wire             push;
    wire             pop;

    assign in_ready  = (count_r != DEPTH[1:0]);
    assign out_valid = (count_r != 2'h0);
    assign out_data  = mem_r[rd_ptr_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'h0;
        end else begin
            if (push) begin
                mem_r[wr_ptr_r] <= in_data;
                wr_ptr_r        <= ~wr_ptr_r;
            end
            if (pop)
                rd_ptr_r <= ~rd_ptr_r;
            if (push & ~pop)
                count_r <= count_r + 2'h1;
            else if (pop & ~push)
                count_r <= count_r - 2'h1;
        end
    end
endmodule // tx_buffer

// ==== rtl/tx_shifter.v ====
`include "uart_consts.vh"

module tx_shifter (
    input  wire       clk,
    input  wire       rst,
    input  wire       tick,
    input  wire [7:0] data,
    input  wire       valid,
    output wire       ready,
    input  wire [1:0] word_len,
    input  wire       two_stop,
    input  wire       par_en,
    input  wire       even_par,
    input  wire       stick_par,
    input  wire       set_break,
    output wire       txd,
    output wire       busy
);
    localparam S_IDLE   = 3'h0;
    localparam S_START  = 3'h1;
    localparam S_DATA   = 3'h2;
    localparam S_PARITY = 3'h3;
    localparam S_STOP   = 3'h4;

    reg  [2:0] state_r;
    reg  [2:0] state_nxt;
    reg  [7:0] shift_r;
    reg        par_r;
    reg  [2:0] bit_r;
    reg  [4:0] cnt_r;
    reg        txd_r;
    reg        line_nxt;
    reg  [7:0] mask;
    reg  [4:0] limit;
    wire       bit_end;
    wire [7:0] masked;

    always @* begin
        case (word_len)
            2'h0:    mask = 8'h1f;
            2'h1:    mask = 8'h3f;
            2'h2:    mask = 8'h7f;
            default: mask = 8'hff;
        endcase
    end
    assign masked  = data & mask; // R19

    always @* begin
        if (state_r != S_STOP || !two_stop)
            limit = `TICKS_BIT;
        else if (word_len == 2'h0)
            limit = `TICKS_STOP15;
        else
            limit = `TICKS_STOP2;
    end

    assign ready   = (state_r == S_IDLE);
    assign busy    = (state_r != S_IDLE);
    assign bit_end = tick && (cnt_r == limit);
    assign txd     = txd_r;

    always @* begin
        state_nxt = state_r;
        line_nxt  = 1'b1;
        case (state_r)
            S_IDLE: begin
                if (valid)
                    state_nxt = S_START;
            end
            S_START: begin
                line_nxt = 1'b0;
                if (bit_end)
                    state_nxt = S_DATA;
            end
            S_DATA: begin
                line_nxt = shift_r[0]; // R18
                if (bit_end && bit_r == {1'b0, word_len} + 3'h4)
                    state_nxt = par_en ? S_PARITY : S_STOP;
            end
            S_PARITY: begin
                line_nxt = par_r;
                if (bit_end)
                    state_nxt = S_STOP;
            end
            S_STOP: begin
                if (bit_end)
                    state_nxt = S_IDLE;
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            state_r <= S_IDLE;
            shift_r <= 8'h00;
            par_r   <= 1'b0;
            bit_r   <= 3'h0;
            cnt_r   <= 5'h00;
            txd_r   <= 1'b1;
        end else begin
            state_r <= state_nxt;
            txd_r   <= set_break ? 1'b0 : line_nxt;
            if (state_r == S_IDLE && valid) begin
                // Word taken as the start bit begins
                shift_r <= masked; // R13
                par_r   <= stick_par ? ~even_par
                         : (even_par ? ^masked : ~^masked);
                bit_r   <= 3'h0;
                cnt_r   <= 5'h00;
            end else if (tick) begin
                if (bit_end) begin
                    cnt_r <= 5'h00;
                    if (state_r == S_DATA) begin
                        shift_r <= {1'b0, shift_r[7:1]}; // R18
                        bit_r   <= bit_r + 3'h1;
                    end
                end else begin
                    cnt_r <= cnt_r + 5'h01;
                end
            end
        end
    end
endmodule // tx_shifter

// ==== rtl/uart_top.v ====
`include "uart_consts.vh"

// Functional notes
// R1: Identification bit 0 low while enabled source pending
// R2: Identification bits 1-2 name top pending source
// R3: Priority line, receive, holding empty, modem
// R4: Each source cleared by its own access
// R5: Identification bits 3-7 read zero
// R6: Enable bits: data, holding, line, modem
// R7: Enable bits 4-7 held zero
// R8: All enables clear suppress identification and output
// R9: Status flags keep working with interrupts off
// R10: Output high while any enabled source pending
// R11: Five to eight bit characters via data bus
// R12: Host writes only while holding empty high
// R13: Holding empty rises at start-bit transfer
// R14: Idle both flags high, write clears holding
// R15: Transmitter empty low through whole character
// R16: Second character waits while shifter busy
// R17: Holding empty follows final transfer
// R18: Least significant bit shifted first
// R19: Upper unused bits ignored, shared format
// R20: Reset sets both empty flags
module uart_top (
    input  wire       CLK_SYS,
    input  wire       RST,
    input  wire [2:0] ADDR,
    input  wire       CS_N,
    input  wire       RD_N,
    input  wire       WR_N,
    input  wire [7:0] HOST_DATA_BUS_IN,
    output wire [7:0] HOST_DATA_BUS_OUT,
    output wire       HOST_DATA_BUS_OE,
    output wire       INTERRUPT_OUTPUT,
    output wire       TXD,
    output wire       TICK16,
    output wire [4:0] CHAR_FORMAT,
    input  wire [7:0] RX_CHAR,
    input  wire       RX_CHAR_STROBE,
    input  wire       RX_PARITY_ERR,
    input  wire       RX_FRAME_ERR,
    input  wire       RX_BREAK,
    input  wire       CTS_N,
    input  wire       DSR_N,
    input  wire       RI_N,
    input  wire       DCD_N,
    output wire       RTS_N,
    output wire       DTR_N,
    output wire       OUT1_N,
    output wire       OUT2_N
);
    wire [17:0] pin_raw;
    wire [17:0] pin_idle;
    wire [15:0] div_reset;
    reg  [17:0] sync1_r;
    reg  [17:0] sync2_r;
    reg  [17:0] sync3_r;
    reg  [17:0] clean_r;
    wire [2:0]  addr_c;
    wire [7:0]  din_c;
    wire        rd_act;
    wire        wr_act;
    reg         rd_act_q;
    reg         wr_act_q;
    reg  [2:0]  wr_addr_r;
    reg  [7:0]  wr_data_r;
    wire        rd_start;
    wire        wr_end;
    reg  [7:0]  rd_data_r;
    reg  [7:0]  rd_mux;

    reg  [7:0]  ier_r;
    reg  [7:0]  lcr_r;
    reg  [7:0]  mcr_r;
    reg  [7:0]  scr_r;
    reg  [7:0]  dll_r;
    reg  [7:0]  dlm_r;
    reg  [7:0]  rbr_r;
    reg  [15:0] baud_cnt_r;
    reg         tick_r;
    wire        div_wr;

    reg         dr_r;
    reg         oe_r;
    reg         pe_r;
    reg         fe_r;
    reg         bi_r;
    reg  [3:0]  mstat_q;
    reg  [3:0]  delta_r;
    wire [3:0]  mstat;
    wire [3:0]  delta_set;
    reg         holding_empty_flag_q;
    reg         holding_empty_flag_pend_r;
    reg         int_r;
    reg  [2:0]  iir_code;

    wire        divisor_access_select;
    wire        rd_rbr;
    wire        rd_iir;
    wire        rd_lsr;
    wire        rd_msr;
    wire        wr_thr;
    wire [7:0]  buf_data;
    wire        buf_valid;
    wire        sh_ready;
    wire        sh_busy;
    wire        holding_empty_flag;
    wire        transmitter_empty_flag;
    wire        line_pend;
    wire        modem_pend;
    wire [7:0]  lsr_val;
    wire [7:0]  msr_val;

    // Three-stage synchronisers on every host and modem pin
    assign pin_raw = {ADDR, HOST_DATA_BUS_IN, CS_N, RD_N, WR_N,
                      CTS_N, DSR_N, RI_N, DCD_N};
    assign pin_idle  = `PIN_IDLE;
    assign div_reset = `DIV_RESET;
    genvar g;
    generate
        for (g = 0; g < 18; g = g + 1) begin : pin_sync
            always @(posedge CLK_SYS) begin
                if (RST) begin
                    sync1_r[g] <= pin_idle[g];
                    sync2_r[g] <= pin_idle[g];
                    sync3_r[g] <= pin_idle[g];
                    clean_r[g] <= pin_idle[g];
                end else begin
                    sync1_r[g] <= pin_raw[g];
                    sync2_r[g] <= sync1_r[g];
                    sync3_r[g] <= sync2_r[g];
                    if (sync2_r[g] == sync3_r[g])
                        clean_r[g] <= sync3_r[g];
                end
            end
        end
    endgenerate

    assign addr_c   = clean_r[17:15];
    assign din_c    = clean_r[14:7];
    assign rd_act   = ~clean_r[6] & ~clean_r[5];
    assign wr_act   = ~clean_r[6] & ~clean_r[4];
    assign rd_start = rd_act & ~rd_act_q;
    assign wr_end   = wr_act_q & ~wr_act;
    assign divisor_access_select     = lcr_r[`LCR_DIVSEL];

    // Access decode: read effects at read start, write at strobe end
    assign rd_rbr = rd_start && addr_c == `OFS_DATA && !divisor_access_select;
    assign rd_iir = rd_start && addr_c == `OFS_IIR;
    assign rd_lsr = rd_start && addr_c == `OFS_LSR;
    assign rd_msr = rd_start && addr_c == `OFS_MSR;
    assign wr_thr = wr_end && wr_addr_r == `OFS_DATA && !divisor_access_select;
    assign div_wr = wr_end && divisor_access_select && (wr_addr_r == `OFS_DATA
                    || wr_addr_r == `OFS_IER_DIVHI);

    // Status words
    assign holding_empty_flag    = ~buf_valid; // R14
    assign transmitter_empty_flag    = ~buf_valid & ~sh_busy; // R15
    assign lsr_val = {1'b0, transmitter_empty_flag, holding_empty_flag, bi_r, fe_r, pe_r, oe_r, dr_r};
    assign mstat   = mcr_r[`MCR_LOOP] ? {mcr_r[3], mcr_r[2], mcr_r[0],
                     mcr_r[1]} : {~clean_r[0], ~clean_r[1],
                     ~clean_r[2], ~clean_r[3]};
    assign msr_val = {mstat, delta_r};
    assign delta_set = {mstat[3] ^ mstat_q[3], ~mstat[2] & mstat_q[2],
                        mstat[1] ^ mstat_q[1], mstat[0] ^ mstat_q[0]};
    assign line_pend  = oe_r | pe_r | fe_r | bi_r;
    assign modem_pend = |delta_r;

    always @* begin
        if (line_pend && ier_r[`IER_LINE]) // R3
            iir_code = `IIR_LINE;
        else if (dr_r && ier_r[`IER_RXD])
            iir_code = `IIR_RXD;
        else if (holding_empty_flag_pend_r && ier_r[`IER_HOLDING_EMPTY_FLAG])
            iir_code = `IIR_HOLDING_EMPTY_FLAG;
        else if (modem_pend && ier_r[`IER_MODEM])
            iir_code = `IIR_MODEM;
        else
            iir_code = `IIR_NONE; // R8
    end

    always @* begin
        if (addr_c == `OFS_DATA)
            rd_mux = divisor_access_select ? dll_r : rbr_r;
        else if (addr_c == `OFS_IER_DIVHI)
            rd_mux = divisor_access_select ? dlm_r : ier_r;
        else if (addr_c == `OFS_IIR)
            rd_mux = {5'h00, iir_code}; // R1 R2 R5
        else if (addr_c == `OFS_LCR)
            rd_mux = lcr_r;
        else if (addr_c == `OFS_MCR)
            rd_mux = mcr_r;
        else if (addr_c == `OFS_LSR)
            rd_mux = lsr_val;
        else if (addr_c == `OFS_MSR)
            rd_mux = msr_val;
        else
            rd_mux = scr_r;
    end

    // Host bus and control registers
    always @(posedge CLK_SYS) begin
        if (RST) begin
            rd_act_q  <= 1'b0;
            wr_act_q  <= 1'b0;
            wr_addr_r <= 3'h0;
            wr_data_r <= 8'h00;
            rd_data_r <= 8'h00;
            ier_r     <= `IER_RESET;
            lcr_r     <= `LCR_RESET;
            mcr_r     <= `MCR_RESET;
            scr_r     <= 8'h00;
            dll_r     <= div_reset[7:0];
            dlm_r     <= div_reset[15:8];
        end else begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
            if (wr_act) begin
                wr_addr_r <= addr_c;
                wr_data_r <= din_c;
            end
            if (rd_start)
                rd_data_r <= rd_mux;
            if (wr_end) begin
                if (wr_addr_r == `OFS_DATA) begin
                    if (divisor_access_select)
                        dll_r <= wr_data_r;
                end else if (wr_addr_r == `OFS_IER_DIVHI) begin
                    if (divisor_access_select)
                        dlm_r <= wr_data_r;
                    else
                        ier_r <= wr_data_r & `IER_MASK; // R6 R7
                end else if (wr_addr_r == `OFS_LCR) begin
                    lcr_r <= wr_data_r;
                end else if (wr_addr_r == `OFS_MCR) begin
                    mcr_r <= wr_data_r & `MCR_MASK;
                end else if (wr_addr_r == `OFS_SCR) begin
                    scr_r <= wr_data_r;
                end
            end
        end
    end

    // Baud generator: one tick per sixteenth of a bit
    always @(posedge CLK_SYS) begin
        if (RST) begin
            baud_cnt_r <= `DIV_RESET;
            tick_r     <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (div_wr) begin
                baud_cnt_r <= (wr_addr_r == `OFS_DATA)
                              ? {dlm_r, wr_data_r} : {wr_data_r, dll_r};
            end else if ({dlm_r, dll_r} != 16'h0000) begin
                if (baud_cnt_r <= 16'h0001) begin
                    baud_cnt_r <= {dlm_r, dll_r};
                    tick_r     <= 1'b1;
                end else begin
                    baud_cnt_r <= baud_cnt_r - 16'h0001;
                end
            end
        end
    end

    // Line and modem status; a new event wins over a clearing read
    always @(posedge CLK_SYS) begin
        if (RST) begin
            rbr_r       <= 8'h00;
            dr_r        <= 1'b0;
            oe_r        <= 1'b0;
            pe_r        <= 1'b0;
            fe_r        <= 1'b0;
            bi_r        <= 1'b0;
            mstat_q     <= 4'h0;
            delta_r     <= 4'h0;
            holding_empty_flag_q      <= 1'b1;
            holding_empty_flag_pend_r <= 1'b1; // R20
            int_r       <= 1'b0;
        end else begin
            if (RX_CHAR_STROBE)
                rbr_r <= RX_CHAR;
            dr_r <= (dr_r & ~rd_rbr) | RX_CHAR_STROBE; // R4 R9
            oe_r <= (oe_r & ~rd_lsr) | (RX_CHAR_STROBE & dr_r & ~rd_rbr);
            pe_r <= (pe_r & ~rd_lsr) | (RX_CHAR_STROBE & RX_PARITY_ERR);
            fe_r <= (fe_r & ~rd_lsr) | (RX_CHAR_STROBE & RX_FRAME_ERR);
            bi_r <= (bi_r & ~rd_lsr) | (RX_CHAR_STROBE & RX_BREAK);
            mstat_q <= mstat;
            delta_r <= (delta_r & {4{~rd_msr}}) | delta_set; // R4 R9
            holding_empty_flag_q  <= holding_empty_flag;
            holding_empty_flag_pend_r <= (holding_empty_flag_pend_r & ~wr_thr
                            & ~(rd_iir && iir_code == `IIR_HOLDING_EMPTY_FLAG))
                           | (holding_empty_flag & ~holding_empty_flag_q); // R4 R13 R17
            int_r <= (iir_code != `IIR_NONE); // R8 R10
        end
    end

    tx_buffer #(
        .WIDTH (8),
        .DEPTH (2)
    ) u_holding (
        .clk       (CLK_SYS),
        .rst       (RST),
        .in_data   (wr_data_r), // R11
        .in_valid  (wr_thr), // R14
        .in_ready  (),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (sh_ready) // R16
    );

    tx_shifter u_shifter (
        .clk       (CLK_SYS),
        .rst       (RST),
        .tick      (tick_r),
        .data      (buf_data),
        .valid     (buf_valid),
        .ready     (sh_ready),
        .word_len  (lcr_r[1:0]),
        .two_stop  (lcr_r[`LCR_STB]),
        .par_en    (lcr_r[`LCR_PEN]),
        .even_par  (lcr_r[`LCR_EPS]),
        .stick_par (lcr_r[`LCR_STICK]),
        .set_break (lcr_r[`LCR_BREAK]),
        .txd       (TXD),
        .busy      (sh_busy)
    );

    assign HOST_DATA_BUS_OUT = rd_data_r;
    assign HOST_DATA_BUS_OE  = rd_act_q;
    assign INTERRUPT_OUTPUT  = int_r;
    assign TICK16            = tick_r;
    assign CHAR_FORMAT       = lcr_r[4:0]; // R19
    assign RTS_N             = ~mcr_r[1];
    assign DTR_N             = ~mcr_r[0];
    assign OUT1_N            = ~mcr_r[2];
    assign OUT2_N            = ~mcr_r[3];
endmodule // uart_top

// ==== dv/uart_top_chk.sv ====
module uart_top_chk (
    input wire       CLK_SYS,
    input wire       RST,
    input wire       CS_N,
    input wire       RD_N,
    input wire       WR_N,
    input wire [7:0] HOST_DATA_BUS_OUT,
    input wire       HOST_DATA_BUS_OE,
    input wire       INTERRUPT_OUTPUT,
    input wire       TXD,
    input wire       RTS_N,
    input wire       DTR_N
);
    timeunit 1ns;
    timeprecision 1ns;
    reg wrote_r;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // Any host write seen since reset
    always @(posedge CLK_SYS)
        if (RST)
            wrote_r <= 1'b0;
        else if (!CS_N && !WR_N)
            wrote_r <= 1'b1;
    chk_reset_outs_idle: assert property (
        $fell(RST) |-> TXD && !INTERRUPT_OUTPUT && RTS_N && DTR_N)
        else $error("outputs not idle after reset");
    chk_oe_after_read: assert property (
        $rose(HOST_DATA_BUS_OE) |-> !$past(RD_N, 2) && !$past(CS_N, 2))
        else $error("bus driven without a read");
    chk_oe_holds_read: assert property (
        HOST_DATA_BUS_OE && !RD_N && !CS_N |=> HOST_DATA_BUS_OE)
        else $error("bus released during read");
    chk_oe_release_bound: assert property (
        $rose(RD_N) |-> ##[1:6] !HOST_DATA_BUS_OE)
        else $error("bus not released after read");
    chk_read_data_stable: assert property (
        HOST_DATA_BUS_OE && $past(HOST_DATA_BUS_OE) |->
            $stable(HOST_DATA_BUS_OUT))
        else $error("read data changed while driven");
    chk_irq_needs_enable: assert property (
        !wrote_r |-> !INTERRUPT_OUTPUT)
        else $error("interrupt with all enables clear");
    chk_txd_idle_early: assert property (
        !wrote_r |-> TXD)
        else $error("line not idle before any write");
    chk_low_run_min: assert property (
        $fell(TXD) |-> !TXD [*8] ##1 !TXD [*8])
        else $error("low bit shorter than sixteen cycles");
    chk_high_run_min: assert property (
        $rose(TXD) |-> TXD [*8] ##1 TXD [*8])
        else $error("high bit shorter than sixteen cycles");
endmodule // uart_top_chk

bind uart_top uart_top_chk chk_u (
    .CLK_SYS           (CLK_SYS),
    .RST               (RST),
    .CS_N              (CS_N),
    .RD_N              (RD_N),
    .WR_N              (WR_N),
    .HOST_DATA_BUS_OUT (HOST_DATA_BUS_OUT),
    .HOST_DATA_BUS_OE  (HOST_DATA_BUS_OE),
    .INTERRUPT_OUTPUT  (INTERRUPT_OUTPUT),
    .TXD               (TXD),
    .RTS_N             (RTS_N),
    .DTR_N             (DTR_N)
);

// ==== dv/host_bus.sv ====
module host_bus (
    input  wire logic       clk,
    input  wire logic [7:0] bus_in,
    input  wire logic       bus_oe,
    output logic      [2:0] addr,
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic      [7:0] bus_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        addr = 3'h0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        bus_out = 8'h00;
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        addr = a;
        bus_out = d;
        cs_n = 1'b0;
        wr_n = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        wr_n = 1'b1;
        cs_n = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        // Released lines do not keep the last value
        bus_out = ~d;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d,
                      output logic ok);
        int n;
        ok = 1'b0;
        d = 8'hxx;
        @(posedge clk) #1;
        addr = a;
        cs_n = 1'b0;
        rd_n = 1'b0;
        for (n = 0; n < 12; n++) begin
            @(posedge clk);
            if (!ok && bus_oe === 1'b1) begin
                ok = 1'b1;
                d = bus_in;
            end
            if (ok && n >= 4)
                break;
        end
        #1;
        rd_n = 1'b1;
        cs_n = 1'b1;
        repeat (5) @(posedge clk);
    endtask
    task automatic put_char(input logic [7:0] d, output logic ok);
        logic [7:0] s;
        int         n;
        ok = 1'b0;
        for (n = 0; n < 400 && !ok; n++) begin
            rd(3'h5, s, ok);
            ok = ok && (s[5] === 1'b1);
        end
        if (ok)
            wr(3'h0, d);
    endtask
endmodule // host_bus

// ==== dv/uart_top_tb.sv ====
module uart_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       CLK_SYS;
    logic       RST;
    logic [7:0] RX_CHAR;
    logic       RX_CHAR_STROBE;
    logic       RX_PARITY_ERR;
    logic       CTS_N;
    wire  [2:0] ADDR;
    wire        CS_N;
    wire        RD_N;
    wire        WR_N;
    wire  [7:0] HOST_DATA_BUS_IN;
    wire  [7:0] HOST_DATA_BUS_OUT;
    wire        HOST_DATA_BUS_OE;
    wire        INTERRUPT_OUTPUT;
    wire        TXD;
    wire  [4:0] CHAR_FORMAT;
    int         err_total = 0;
    int         samples_checked = 0;
    uart_top dut_u (
        .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .CS_N(CS_N),
        .RD_N(RD_N), .WR_N(WR_N), .HOST_DATA_BUS_IN(HOST_DATA_BUS_IN),
        .HOST_DATA_BUS_OUT(HOST_DATA_BUS_OUT),
        .HOST_DATA_BUS_OE(HOST_DATA_BUS_OE),
        .INTERRUPT_OUTPUT(INTERRUPT_OUTPUT), .TXD(TXD), .TICK16(),
        .CHAR_FORMAT(CHAR_FORMAT), .RX_CHAR(RX_CHAR),
        .RX_CHAR_STROBE(RX_CHAR_STROBE),
        .RX_PARITY_ERR(RX_PARITY_ERR), .RX_FRAME_ERR(1'b0),
        .RX_BREAK(1'b0), .CTS_N(CTS_N), .DSR_N(1'b1), .RI_N(1'b1),
        .DCD_N(1'b1), .RTS_N(), .DTR_N(), .OUT1_N(), .OUT2_N()
    );
    host_bus host_u (
        .clk(CLK_SYS), .bus_in(HOST_DATA_BUS_OUT),
        .bus_oe(HOST_DATA_BUS_OE), .addr(ADDR), .cs_n(CS_N),
        .rd_n(RD_N), .wr_n(WR_N), .bus_out(HOST_DATA_BUS_IN)
    );
    initial begin
        CLK_SYS = 1'b0;
        forever #50 CLK_SYS = ~CLK_SYS;
    end
    task automatic final_report;
        $display("compared %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic timed_out;
        err_total++;
        $display("wait bound used up at %0t", $time);
        final_report();
    endtask
    task automatic check(input logic [9:0] g, input logic [9:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        host_u.rd(a, d, ok);
        if (ok !== 1'b1)
            timed_out();
        check({2'b00, d}, {2'b00, e});
    endtask
    task automatic int_is(input logic e);
        #2;
        check({9'h000, INTERRUPT_OUTPUT}, {9'h000, e});
    endtask
    // Start, n data bits, stop, each sampled mid-bit
    task automatic get_frame(input int n, output logic [9:0] v);
        int k;
        v = 10'h000;
        for (k = 0; TXD !== 1'b0; k++) begin
            if (k > 4000)
                timed_out();
            @(posedge CLK_SYS) #2;
        end
        repeat (8) @(posedge CLK_SYS) #2;
        for (k = 0; k <= n + 1; k++) begin
            v[k] = TXD;
            if (k <= n)
                repeat (16) @(posedge CLK_SYS) #2;
        end
    endtask
    task automatic reset_values;
        rc(3'h5, 8'h60);
        rc(3'h1, 8'h00);
        rc(3'h2, 8'h01);
        host_u.wr(3'h2, 8'hff);
        rc(3'h2, 8'h01);
        int_is(1'b0);
    endtask
    task automatic irq_holding;
        host_u.wr(3'h1, 8'hff);
        rc(3'h1, 8'h0f);
        int_is(1'b1);
        rc(3'h2, 8'h02);
        rc(3'h2, 8'h01);
        int_is(1'b0);
        host_u.wr(3'h1, 8'h00);
    endtask
    task automatic tx_formats;
        logic [9:0] f;
        logic [9:0] e;
        logic       ok;
        int         n;
        for (n = 5; n <= 8; n++) begin
            repeat (10) @(posedge CLK_SYS);
            host_u.wr(3'h3, 8'(n - 5));
            e = (10'h1 << (n + 1)) | ((10'h096 & ((10'h1 << n) - 1)) << 1);
            fork
                host_u.put_char(8'h96, ok);
                get_frame(n, f);
            join
            check(f, e);
            check({9'h000, ok}, 10'h001);
            check({5'h00, CHAR_FORMAT}, 10'(n - 5));
        end
        // Seven bits, odd parity: bit 7 must not reach the line
        host_u.wr(3'h3, 8'h0a);
        fork
            host_u.put_char(8'h96, ok);
            get_frame(8, f);
        join
        check(f, 10'h22c);
        host_u.wr(3'h3, 8'h03);
    endtask
    task automatic tx_pair;
        logic [9:0] f1;
        logic [9:0] f2;
        logic       ok;
        fork
            begin
                get_frame(8, f1);
                get_frame(8, f2);
            end
            begin
                host_u.put_char(8'ha5, ok);
                check({9'h000, ok}, 10'h001);
                host_u.put_char(8'h3c, ok);
                check({9'h000, ok}, 10'h001);
                rc(3'h5, 8'h00);
                repeat (200) @(posedge CLK_SYS);
                rc(3'h5, 8'h20);
            end
        join
        check(f1, 10'h34a);
        check(f2, 10'h278);
        repeat (20) @(posedge CLK_SYS);
        rc(3'h5, 8'h60);
    endtask
    task automatic irq_sources;
        @(posedge CLK_SYS) #1;
        RX_CHAR = 8'h5a;
        RX_PARITY_ERR = 1'b1;
        RX_CHAR_STROBE = 1'b1;
        @(posedge CLK_SYS) #1;
        RX_CHAR_STROBE = 1'b0;
        RX_PARITY_ERR = 1'b0;
        RX_CHAR = 8'ha5;
        repeat (4) @(posedge CLK_SYS);
        int_is(1'b0);
        rc(3'h2, 8'h01);
        host_u.wr(3'h1, 8'h0f);
        rc(3'h2, 8'h06);
        rc(3'h5, 8'h65);
        rc(3'h2, 8'h04);
        rc(3'h0, 8'h5a);
        rc(3'h2, 8'h02);
        rc(3'h2, 8'h01);
        @(posedge CLK_SYS) #1;
        CTS_N = 1'b0;
        repeat (8) @(posedge CLK_SYS);
        rc(3'h2, 8'h00);
        int_is(1'b1);
        rc(3'h6, 8'h11);
        rc(3'h2, 8'h01);
        int_is(1'b0);
    endtask
    initial begin
        RST = 1'b1;
        RX_CHAR = 8'h00;
        RX_CHAR_STROBE = 1'b0;
        RX_PARITY_ERR = 1'b0;
        CTS_N = 1'b1;
        repeat (10) @(posedge CLK_SYS);
        #1;
        RST = 1'b0;
        reset_values();
        irq_holding();
        tx_formats();
        tx_pair();
        irq_sources();
        final_report();
    end
endmodule // uart_top_tb
